// ### dv/ocw_host_model.sv
`timescale 1ns/1ps
module ocw_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Alert pin as seen by the controller
  input wire logic flag_o,
  input wire logic flag_oe_n,
  output logic pin,
  output int falls
);
  // ----------------------------------------------------------------------
  // Pull-up on the open-drain line
  // ----------------------------------------------------------------------
  // released line pulled high
  assign pin = (flag_oe_n === 1'b0) ? flag_o : 1'b1;

  // ----------------------------------------------------------------------
  // Interrupt-style watch of the line
  // ----------------------------------------------------------------------
  logic pin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b1;
      falls <= 0;
    end else begin
      pin_q <= pin;
      if (pin_q && !pin) begin
        falls <= falls + 1;
      end
    end
  end
endmodule

// ### dv/tb_ocw_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module tb_ocw_top;
  localparam int WC = ocw_pkg::WINDOW_CYCLES;
  localparam logic [15:0] LIM = 16'h03E8;
  localparam logic [15:0] OVER = 16'h044C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fl_o, fl_oe_n, irq, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] lvl;
  logic er, pin_q;
  int bad_count, check_count, falls, ecnt, fmod, tcnt, n, b;
  logic [1:0] codes [3] = '{ocw_pkg::TRI_FLOAT, ocw_pkg::TRI_GND, ocw_pkg::TRI_SUPPLY};
  logic [3:0] wins [3] = '{ocw_pkg::WIN_SHORT, ocw_pkg::WIN_MID, ocw_pkg::WIN_LONG};
  logic [15:0] hyss [3] = '{ocw_pkg::HYS_SMALL, ocw_pkg::HYS_MID, ocw_pkg::HYS_LARGE};

  ocw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensed_input_level(lvl), .overcurrent_flag_n_i(pin),
    .overcurrent_flag_n_o(fl_o), .overcurrent_flag_n_oe_n(fl_oe_n), .irq(irq));
  ocw_host_model host (.pclk(pclk), .presetn(presetn), .flag_o(fl_o), .flag_oe_n(fl_oe_n),
    .pin(pin), .falls(falls));

  // ----------------------------------------------------------------------
  // Clock, edge count and timeout
  // ----------------------------------------------------------------------
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ecnt <= 0;
    else ecnt <= ecnt + 1;
  end
  always @(posedge pclk) begin
    tcnt++;
    if (tcnt == 40000) begin
      bad_count++;
      conclude();
    end
  end
  always @(negedge pclk) begin
    if (pin_q === 1'b1 && pin === 1'b0) begin
      if (fmod < 0) fmod = ecnt % WC;
      else `CHK("fall_phase", fmod, ecnt % WC)
    end
    pin_q = pin;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic ctrl(input logic [1:0] h, input logic [1:0] dl, input logic hd, input logic en);
    apb(1'b1, ocw_pkg::CTRL_OFS, {26'h0000000, h, dl, hd, en});
  endtask
  task automatic wait_pin(input logic lv, input int mx);
    n = 0;
    while (pin !== lv && n < mx) begin @(negedge pclk); n++; end
    @(posedge pclk);
  endtask
  task automatic hold_cnt(input logic lv, input int c);
    b = 0;
    repeat (c) begin @(negedge pclk); if (pin !== lv) b++; end
    @(posedge pclk);
  endtask
  task automatic align();
    while (ecnt % WC != WC - 1) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    `CHK("oe_n_rst", 1'b1, fl_oe_n)
    apb(1'b0, ocw_pkg::CTRL_OFS, 32'h0); `CHK("ctrl_rst", {26'h0, ocw_pkg::CTRL_RESET}, d)
    apb(1'b0, ocw_pkg::THRESH_OFS, 32'h0); `CHK("thr_rst", {16'h0, ocw_pkg::THRESH_RESET}, d)
    apb(1'b0, ocw_pkg::IRQ_MASK_OFS, 32'h0); `CHK("msk_rst", {29'h0, ocw_pkg::IRQ_RESET}, d)
    apb(1'b0, 12'h020, 32'h0); `CHK("unmapped", 33'h100000000, {er, d})
    apb(1'b1, ocw_pkg::STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, ocw_pkg::STATUS_OFS, 32'h0); `CHK("status_ro", 32'h0, d)
    apb(1'b1, ocw_pkg::THRESH_OFS, {16'h0, LIM});
    apb(1'b0, ocw_pkg::THRESH_OFS, 32'h0); `CHK("thr_wr", {16'h0, LIM}, d)
  endtask
  task automatic t_delay();
    for (int k = 0; k < 3; k++) begin
      ctrl(2'h0, 2'h0, 1'b0, 1'b0);
      lvl <= OVER;
      repeat (WC) @(posedge pclk);
      ctrl(2'h0, codes[k], 1'b0, 1'b1);
      wait_pin(1'b0, 2100);
      `CHK("dly_lo", 1'b1, n > (wins[k] - 1) * WC)
      `CHK("dly_hi", 1'b1, n <= wins[k] * WC + 4)
      `CHK("drive_lvl", 1'b0, fl_o)
      if (k == 0) begin
        apb(1'b0, ocw_pkg::IRQ_STAT_OFS, 32'h0); `CHK("rise_stat", 1'b1, d[0])
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, ocw_pkg::IRQ_MASK_OFS, 32'h1);
        @(negedge pclk); `CHK("irq_on", 1'b1, irq)
        apb(1'b1, ocw_pkg::IRQ_STAT_OFS, 32'h1);
        @(negedge pclk); `CHK("irq_clr", 1'b0, irq)
      end
      ctrl(2'h0, codes[k], 1'b0, 1'b0);
      wait_pin(1'b1, 3);
      `CHK("dis_release", 1'b1, pin)
      if (k == 0) begin
        apb(1'b0, ocw_pkg::IRQ_STAT_OFS, 32'h0); `CHK("fall_stat", 3'h6, d[2:0])
        apb(1'b1, ocw_pkg::IRQ_STAT_OFS, 32'h7);
        apb(1'b1, ocw_pkg::IRQ_MASK_OFS, 32'h0);
      end
    end
  endtask
  task automatic t_hys();
    for (int k = 0; k < 3; k++) begin
      ctrl(2'h0, 2'h0, 1'b0, 1'b0);
      lvl <= OVER;
      ctrl(codes[k], 2'h0, 1'b0, 1'b1);
      wait_pin(1'b0, 450); `CHK("tr_alert", 1'b0, pin)
      apb(1'b0, ocw_pkg::STATUS_OFS, 32'h0); `CHK("st_alert", 1'b1, d[0])
      lvl <= LIM - hyss[k] + 16'h000A;
      hold_cnt(1'b0, 600); `CHK("hys_band", 0, b)
      lvl <= LIM - hyss[k] - 16'h000A;
      wait_pin(1'b1, 450); `CHK("tr_release", 1'b1, pin)
    end
  endtask
  task automatic t_streak();
    ctrl(2'h0, 2'h0, 1'b0, 1'b0);
    lvl <= OVER;
    ctrl(2'h0, ocw_pkg::TRI_GND, 1'b0, 1'b1);
    hold_cnt(1'b1, 500); `CHK("short_burst", 0, b)
    lvl <= 16'h0000;
    hold_cnt(1'b1, 400);
    align();
    lvl <= OVER;
    wait_pin(1'b0, 1300); `CHK("streak_restart", 1'b1, n > 780 && n <= 1004)
  endtask
  task automatic t_disable();
    ctrl(2'h0, 2'h0, 1'b0, 1'b0);
    lvl <= OVER;
    ctrl(2'h0, ocw_pkg::TRI_SUPPLY, 1'b0, 1'b1);
    hold_cnt(1'b1, 1000); `CHK("long_wait", 0, b)
    ctrl(2'h0, ocw_pkg::TRI_SUPPLY, 1'b0, 1'b0);
    apb(1'b0, ocw_pkg::STATUS_OFS, 32'h0); `CHK("cnt_cleared", 4'h0, d[7:4])
    hold_cnt(1'b1, 100);
    ctrl(2'h0, ocw_pkg::TRI_SUPPLY, 1'b0, 1'b1);
    wait_pin(1'b0, 2100); `CHK("cnt_restart", 1'b1, n > 1780 && n <= 2004)
  endtask
  task automatic t_latch();
    ctrl(2'h0, 2'h0, 1'b0, 1'b0);
    lvl <= OVER;
    ctrl(2'h0, 2'h0, 1'b1, 1'b1);
    wait_pin(1'b0, 450);
    lvl <= 16'h0000;
    hold_cnt(1'b0, 600); `CHK("latched", 0, b)
    lvl <= OVER;
    repeat (WC) @(posedge pclk);
    // hold select kept low well over 20 us
    ctrl(2'h0, 2'h0, 1'b0, 1'b1);
    hold_cnt(1'b0, 600); `CHK("clr_still_over", 0, b)
    lvl <= 16'h0000;
    wait_pin(1'b1, 450); `CHK("clr_release", 1'b1, pin)
    ctrl(2'h0, 2'h0, 1'b1, 1'b1);
    lvl <= OVER;
    wait_pin(1'b0, 450);
    lvl <= 16'h0000;
    hold_cnt(1'b0, 600); `CHK("rearmed", 0, b)
    ctrl(2'h0, 2'h0, 1'b0, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; lvl = 16'h0000;
    bad_count = 0; check_count = 0; fmod = -1; tcnt = 0; pin_q = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_delay();
    t_hys();
    t_streak();
    t_disable();
    t_latch();
    `CHK("alert_falls", 10, falls)
    conclude();
  end
endmodule

// ### shared/ocw_pkg.sv
package ocw_pkg;

  // ----------------------------------------------------------------------
  // Clock and comparison window
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int WINDOW_US = 10;
  localparam int WINDOW_CYCLES = WINDOW_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Response delay settings, in windows
  // ----------------------------------------------------------------------
  localparam int DELAY_SHORT_US = 10;
  localparam int DELAY_MID_US = 50;
  localparam int DELAY_LONG_US = 100;
  localparam int QUAL_W = 4;
  localparam logic [QUAL_W-1:0] WIN_SHORT = QUAL_W'(DELAY_SHORT_US / WINDOW_US);
  localparam logic [QUAL_W-1:0] WIN_MID = QUAL_W'(DELAY_MID_US / WINDOW_US);
  localparam logic [QUAL_W-1:0] WIN_LONG = QUAL_W'(DELAY_LONG_US / WINDOW_US);

  // ----------------------------------------------------------------------
  // Levels and hysteresis, one level step is LEVEL_LSB_UV microvolts
  // ----------------------------------------------------------------------
  localparam int LEVEL_W = 16;
  localparam int SUM_W = 24;
  localparam int LEVEL_LSB_UV = 10;
  localparam int HYS_SMALL_MV = 2;
  localparam int HYS_MID_MV = 4;
  localparam int HYS_LARGE_MV = 8;
  localparam logic [LEVEL_W-1:0] HYS_SMALL = LEVEL_W'(HYS_SMALL_MV * 1000 / LEVEL_LSB_UV);
  localparam logic [LEVEL_W-1:0] HYS_MID = LEVEL_W'(HYS_MID_MV * 1000 / LEVEL_LSB_UV);
  localparam logic [LEVEL_W-1:0] HYS_LARGE = LEVEL_W'(HYS_LARGE_MV * 1000 / LEVEL_LSB_UV);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] THRESH_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h010;
  localparam int CTRL_W = 6;
  localparam int IRQ_W = 3;
  localparam int STATUS_ALERT_BIT = 0;
  localparam int STATUS_CNT_LSB = 4;
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  localparam int IRQ_OVER_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [LEVEL_W-1:0] THRESH_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TRI_FLOAT = 2'h0,
    TRI_GND = 2'h1,
    TRI_SUPPLY = 2'h2
  } ocw_tri_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ALERT = 2'h2
  } ocw_state_e;

  typedef struct packed {
    ocw_tri_e hys_sel;
    ocw_tri_e delay_sel;
    logic hold_select;
    logic enable;
  } ocw_ctrl_s;

  typedef struct packed {
    logic done;
    logic [SUM_W-1:0] sum;
  } ocw_win_s;

endpackage

// ### verilog/ocw_top.sv
// How it works
// R1: A window of 10 us runs freely and without any outside control or sync.
// R2: The over-limit decision is made only when a window completes, on its average.
// R3: The 50 us and 100 us settings add 40 us and 90 us over the 10 us setting.
// R4: The hysteresis selection picks 2 mV floating, 4 mV ground and 8 mV supply.
// R5: The alert pin is active low open drain and is driven only during an alert.
// R6: With hold select low the alert follows the comparison result.
// R7: In transparent mode the alert releases after one window below threshold.
// R8: With hold select high an asserted alert stays low when the input falls.
// R9: The controller keeps hold select low for at least 20 us to clear a latch.
// R10: Clearing releases the alert only while the input is below threshold.
// R11: The controller may raise hold select again to re-arm latching.
// R12: The 50 us and 100 us settings need five and ten over windows in a row.
// R13: The delay selection picks 10 us floating, 50 us ground and 100 us supply.
// R14: Disabling clears the window counter, which restarts from zero on enable.
// R15: An asserted alert counts as below only under the limit minus hysteresis.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ocw_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensed level
  input wire logic [ocw_pkg::LEVEL_W-1:0] sensed_input_level,
  // Open-drain alert pin
  input wire logic overcurrent_flag_n_i,
  output logic overcurrent_flag_n_o,
  output logic overcurrent_flag_n_oe_n,
  // Interrupt
  output logic irq
);

  localparam int LW = ocw_pkg::LEVEL_W;
  localparam int SW = ocw_pkg::SUM_W;
  localparam int QW = ocw_pkg::QUAL_W;
  localparam int IW = ocw_pkg::IRQ_W;

  ocw_pkg::ocw_ctrl_s ctrl_reg;
  logic [LW-1:0] threshold_level_reg;
  logic [IW-1:0] irq_stat_reg;
  logic [IW-1:0] irq_stat_next;
  logic [IW-1:0] irq_mask_reg;
  logic [IW-1:0] irq_event;
  logic [QW-1:0] cnt_reg;
  logic [QW-1:0] cnt_next;
  logic [QW-1:0] need_windows;
  logic [LW-1:0] hys_level;
  logic [LW-1:0] low_level;
  logic [SW-1:0] high_sum;
  logic [SW-1:0] low_sum;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic addr_hit;
  logic wr_en;
  logic setup;
  logic over_now;
  logic below_now;
  logic qualify;
  logic alert;
  ocw_pkg::ocw_win_s win;
  ocw_pkg::ocw_state_e state_reg;
  ocw_pkg::ocw_state_e state_next;

  // ----------------------------------------------------------------------
  // Comparison window
  // ----------------------------------------------------------------------
  ocw_window u_window (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sensed_input_level),
    .result(win)
  );

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && addr_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;

  always_comb begin
    rd_data = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      ocw_pkg::CTRL_OFS: begin
        rd_data[ocw_pkg::CTRL_W-1:0] = ctrl_reg;
      end
      ocw_pkg::THRESH_OFS: begin
        rd_data[LW-1:0] = threshold_level_reg;
      end
      ocw_pkg::STATUS_OFS: begin
        rd_data[ocw_pkg::STATUS_ALERT_BIT] = alert;
        rd_data[ocw_pkg::STATUS_CNT_LSB +: QW] = cnt_reg;
      end
      ocw_pkg::IRQ_STAT_OFS: begin
        rd_data[IW-1:0] = irq_stat_reg;
      end
      ocw_pkg::IRQ_MASK_OFS: begin
        rd_data[IW-1:0] = irq_mask_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_data;
    end
  end

  // R9: hold select is written by the controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ocw_pkg::CTRL_RESET;
      threshold_level_reg <= ocw_pkg::THRESH_RESET;
      irq_mask_reg <= ocw_pkg::IRQ_RESET;
    end else if (wr_en) begin
      case (paddr)
        ocw_pkg::CTRL_OFS: begin
          ctrl_reg <= pwdata[ocw_pkg::CTRL_W-1:0];
        end
        ocw_pkg::THRESH_OFS: begin
          threshold_level_reg <= pwdata[LW-1:0];
        end
        ocw_pkg::IRQ_MASK_OFS: begin
          irq_mask_reg <= pwdata[IW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Selections
  // ----------------------------------------------------------------------
  // R4: hysteresis selection.
  always_comb begin
    case (ctrl_reg.hys_sel)
      ocw_pkg::TRI_GND: hys_level = ocw_pkg::HYS_MID;
      ocw_pkg::TRI_SUPPLY: hys_level = ocw_pkg::HYS_LARGE;
      default: hys_level = ocw_pkg::HYS_SMALL;
    endcase
  end

  // R13: delay selection.
  always_comb begin
    case (ctrl_reg.delay_sel)
      ocw_pkg::TRI_GND: need_windows = ocw_pkg::WIN_MID;
      ocw_pkg::TRI_SUPPLY: need_windows = ocw_pkg::WIN_LONG;
      default: need_windows = ocw_pkg::WIN_SHORT;
    endcase
  end

  // ----------------------------------------------------------------------
  // Window decision
  // ----------------------------------------------------------------------
  assign low_level = (threshold_level_reg > hys_level) ? threshold_level_reg - hys_level : '0;
  assign high_sum = SW'(threshold_level_reg * ocw_pkg::WINDOW_CYCLES);
  assign low_sum = SW'(low_level * ocw_pkg::WINDOW_CYCLES);
  // R2: compare window average with the limit.
  assign over_now = win.done && (win.sum > high_sum);
  // R15: release level sits one hysteresis step below the limit.
  assign below_now = win.done && (win.sum < low_sum);

  // R12: consecutive over windows.
  always_comb begin
    cnt_next = cnt_reg;
    if (!ctrl_reg.enable) begin
      cnt_next = '0;
    end else if (win.done) begin
      if (!over_now) begin
        cnt_next = '0;
      end else if (cnt_reg < need_windows) begin
        cnt_next = cnt_reg + QW'(1);
      end
    end
  end

  // R14: disable clears the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // R3: alert after the selected number of windows.
  assign qualify = ctrl_reg.enable && over_now && (cnt_next >= need_windows);

  // ----------------------------------------------------------------------
  // Alert state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ocw_pkg::ST_IDLE: begin
        // R6: alert follows the comparison.
        if (qualify) begin
          state_next = ocw_pkg::ST_ALERT;
        end
      end
      ocw_pkg::ST_ALERT: begin
        // R8: latch holds while hold select and enable are both high.
        if (!ctrl_reg.enable) begin
          state_next = ocw_pkg::ST_IDLE;
        end else if (below_now && !ctrl_reg.hold_select) begin
          // R7: one window below releases.
          // R10: clear only while below.
          state_next = ocw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = ocw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ocw_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign alert = (state_reg == ocw_pkg::ST_ALERT);
  // R5: open drain, driven low only during an alert.
  assign overcurrent_flag_n_o = 1'b0;
  assign overcurrent_flag_n_oe_n = !alert;

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_event = '0;
    irq_event[ocw_pkg::IRQ_RISE_BIT] = !alert && (state_next == ocw_pkg::ST_ALERT);
    irq_event[ocw_pkg::IRQ_FALL_BIT] = alert && (state_next == ocw_pkg::ST_IDLE);
    irq_event[ocw_pkg::IRQ_OVER_BIT] = ctrl_reg.enable && over_now;
  end

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && (paddr == ocw_pkg::IRQ_STAT_OFS)) begin
      irq_stat_next = irq_stat_reg & ~pwdata[IW-1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= ocw_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence release_cause_q;
    ctrl_reg.enable && below_now && !ctrl_reg.hold_select;
  endsequence

  sequence hold_cause_q;
    ctrl_reg.enable && ctrl_reg.hold_select;
  endsequence

  window_period_a: assert property (win.done |-> ##200 win.done) // R1
    else $error("window period is not 200 cycles");
  window_single_a: assert property (win.done |=> !win.done [*8]) // R1
    else $error("window end pulse repeats");
  decide_at_end_a: assert property ($changed(cnt_reg) |-> $past(win.done) || !$past(ctrl_reg.enable)) // R2
    else $error("counter moved outside a window end");
  short_delay_a: assert property ((!alert && state_next == ocw_pkg::ST_ALERT && // R3
      ctrl_reg.delay_sel == ocw_pkg::TRI_FLOAT) |-> over_now)
    else $error("short delay alert without over window");
  mid_count_a: assert property ((!alert && state_next == ocw_pkg::ST_ALERT && // R12
      ctrl_reg.delay_sel == ocw_pkg::TRI_GND) |-> cnt_reg == 4'h4)
    else $error("mid delay alert before five windows");
  long_count_a: assert property ((!alert && state_next == ocw_pkg::ST_ALERT && // R12
      ctrl_reg.delay_sel == ocw_pkg::TRI_SUPPLY) |-> cnt_reg == 4'h9)
    else $error("long delay alert before ten windows");
  count_reset_a: assert property ((ctrl_reg.enable && win.done && !over_now) |=> cnt_reg == 4'h0) // R12
    else $error("under window did not clear counter");
  disable_clear_a: assert property (!ctrl_reg.enable |=> cnt_reg == 4'h0 && !alert) // R14
    else $error("disable did not clear counter");
  hys_level_a: assert property (ctrl_reg.hys_sel == ocw_pkg::TRI_SUPPLY |-> hys_level == 16'h0320) // R4
    else $error("large hysteresis level wrong");
  delay_sel_a: assert property (ctrl_reg.delay_sel == ocw_pkg::TRI_GND |-> need_windows == 4'h5) // R13
    else $error("mid delay selection wrong");
  flag_drive_a: assert property (overcurrent_flag_n_oe_n == !alert && !overcurrent_flag_n_o) // R5
    else $error("alert pin drive does not match alert");
  latch_hold_a: assert property ((alert and hold_cause_q) |=> alert) // R8
    else $error("latched alert released");
  release_a: assert property ((alert and release_cause_q) |=> !alert) // R7
    else $error("alert not released after a window below");
  hyst_keep_a: assert property ((alert && ctrl_reg.enable && !below_now) |=> alert) // R15
    else $error("alert released above the hysteresis band");
  irq_level_a: assert property ($rose(irq_stat_reg[ocw_pkg::IRQ_RISE_BIT]) |-> $rose(alert))
    else $error("rise flag without alert");

endmodule

// ### verilog/ocw_window.sv
`timescale 1ns/1ps
module ocw_window #(
  parameter int LEVEL_W = ocw_pkg::LEVEL_W,
  parameter int SUM_W = ocw_pkg::SUM_W,
  parameter int CYCLES = ocw_pkg::WINDOW_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample in
  input wire logic [LEVEL_W-1:0] sample,
  // Window result
  output ocw_pkg::ocw_win_s result
);

  localparam int CNT_W = $clog2(CYCLES);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic [SUM_W-1:0] acc_reg;
  logic [SUM_W-1:0] acc_next;
  ocw_pkg::ocw_win_s result_reg;

  assign acc_next = acc_reg + SUM_W'(sample);
  assign result = result_reg;

  // ----------------------------------------------------------------------
  // Free-running window
  // ----------------------------------------------------------------------
  // R1: free-running window count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // R2: average taken at window end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
      result_reg <= '0;
    end else if (cnt_reg == LAST) begin
      acc_reg <= '0;
      result_reg.done <= 1'b1;
      result_reg.sum <= acc_next;
    end else begin
      acc_reg <= acc_next;
      result_reg.done <= 1'b0;
    end
  end

endmodule
